// File: inc/asr_pkg.sv
package asr_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned CONV_LOW_US = 133000;
  localparam int unsigned CONV_HIGH_US = 160000;
  localparam int unsigned CONV_EXT_PERIODS = 20510;
  localparam int unsigned DOUT_INT_US = 1280;
  localparam int unsigned DOUT_EXT_PERIODS = 192;
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned SCK_DIV = 8;
  localparam int unsigned EXT_MIN_HZ = 2560;
  localparam int unsigned CONV_LOW_CYC = CONV_LOW_US / 1000 * (CLK_HZ / 1000);
  localparam int unsigned CONV_HIGH_CYC = CONV_HIGH_US / 1000 * (CLK_HZ / 1000);
  localparam int unsigned DOUT_INT_CYC = DOUT_INT_US * (CLK_HZ / 1000000);
  localparam int unsigned EXT_TIMEOUT_CYC = CLK_HZ / EXT_MIN_HZ;
  localparam int unsigned OSC_HALF_CYC = DOUT_INT_CYC / (FRAME_BITS * SCK_DIV * 2);
  localparam int unsigned RESULT_BITS = 20;
  localparam logic [23:0] IDLE_FRAME = 24'h000000;
  typedef enum logic [1:0] {
    ST_CONVERT = 2'b00,
    ST_SLEEP   = 2'b01,
    ST_OUTPUT  = 2'b10
  } asr_state_type;
endpackage

// File: inc/asr_link_if.sv
`timescale 1ns/1ps
interface asr_link_if;
  logic csN;
  logic notchSelect;
  logic sckOut;
  logic sckOe;
  logic hostSck;
  logic hostSckOe;
  logic sdo;
  logic sdoOe;
  wire sckLine = sckOe ? sckOut : (hostSckOe ? hostSck : 1'b1);
  wire sdoLine = sdoOe ? sdo : 1'b1;
  modport dev (input csN, input notchSelect, input sckLine, input sdoLine,
               output sckOut, output sckOe, output sdo, output sdoOe);
  modport host (input sckLine, input sdoLine, output csN, output notchSelect,
                output hostSck, output hostSckOe);
endinterface

// File: rtl/asr_device.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] convert 133ms/160ms or 20510 external periods
// [R2] internal output ends at 1.28ms
// [R3] external conversion clock: output within 192 periods
// [R4] external sck output lasts at most 24 periods
// [R5] internal mode drives sck, divide by eight
// [R6] new bit on falling sck edge
// [R7] clock mode chosen at reset, cs fall
// [R8] host holds sck low for external mode
// [R9] data line released while cs high
// [R10] cs low in convert/sleep shows eoc
// [R11] sleep after conversion, result held static
// [R12] output begins on first rising sck
// [R13] low power in sleep while cs high
// [R14] cs rise during output restarts conversion
// [R15] host may abort readout by cs rise
// [R16] host samples eoc first, lsb 24th
// [R17] 24th falling edge restarts conversion, eoc high
// [R18] clock change only spoils current conversion
// [R19] clock change keeps internal data valid
// [R20] cs tied low converts continuously
// [R21] five timing configurations supported
// [R22] frame: eoc, channel, polarity, range, 20 bits
// [R23] detect external conversion clock, disable oscillator
// [R24] sck edges ignored while cs high
module asr_device (
  input  wire logic       clk,
  input  wire logic       srst,
  asr_link_if.dev         link,
  input  wire logic [19:0] sampleData,
  input  wire logic       channelIndicator,
  input  wire logic       polarityFlag,
  input  wire logic       extendedRangeFlag,
  output logic            lowPower_r,
  output logic            extClkMode_r,
  output logic            convDone_r
);
  asr_pkg::asr_state_type state_r;
  logic        csPrev_r;
  logic        sckPrev_r;
  logic        notchPrev_r;
  logic        intMode_r;
  logic [31:0] convCnt_r;
  logic [31:0] outCnt_r;
  logic [31:0] extGap_r;
  logic [31:0] oscCnt_r;
  logic [2:0]  divCnt_r;
  logic [4:0]  bitCnt_r;
  logic [23:0] shift_r;
  logic        sckDrv_r;
  logic        sdo_r;
  logic        sdoOe_r;
  logic        sckOe_r;
  logic        extTick;
  logic        convTick;
  logic        sckRise;
  logic        sckFall;
  logic        csFall;
  logic        csRise;
  logic        sckIn;
  logic        convEnd;
  logic        outTimeout;

  function automatic logic [23:0] frame_of(input logic ch, input logic pol,
                                            input logic rng, input logic [19:0] d);
    frame_of = {1'b0, ch, pol, rng, d}; // see [R22]
  endfunction

  assign sckIn  = intMode_r ? sckDrv_r : link.sckLine;
  assign csFall = csPrev_r & ~link.csN;
  assign csRise = ~csPrev_r & link.csN;
  assign sckRise = ~sckPrev_r & sckIn & ~link.csN; // see [R24]
  assign sckFall = sckPrev_r & ~sckIn & ~link.csN; // see [R24]
  assign extTick = ~notchPrev_r & link.notchSelect;
  assign convTick = extClkMode_r ? extTick : 1'b1;

  always_ff @(posedge clk) begin
    if (srst) begin
      csPrev_r    <= 1'b1;
      sckPrev_r   <= 1'b1;
      notchPrev_r <= 1'b0;
    end else begin
      csPrev_r    <= link.csN;
      sckPrev_r   <= sckIn;
      notchPrev_r <= link.notchSelect;
    end
  end

  // external conversion clock is recognised by edges faster than the minimum rate
  always_ff @(posedge clk) begin
    if (srst) begin
      extGap_r     <= '0;
      extClkMode_r <= 1'b0;
    end else if (extTick) begin
      extGap_r     <= '0;
      extClkMode_r <= (extGap_r < asr_pkg::EXT_TIMEOUT_CYC); // see [R23]
    end else if (extGap_r < asr_pkg::EXT_TIMEOUT_CYC) begin
      extGap_r <= extGap_r + 32'd1;
    end else begin
      extClkMode_r <= 1'b0; // see [R23]
    end
  end

  // mode strap taken one cycle after reset release too, since csPrev starts high
  always_ff @(posedge clk) begin
    if (srst) begin
      intMode_r <= 1'b1;
    end else if (csFall) begin
      intMode_r <= link.sckLine; // see [R7] [R8] [R21]
    end
  end

  assign convEnd = extClkMode_r ? (convCnt_r >= asr_pkg::CONV_EXT_PERIODS)
                 : (convCnt_r >= (link.notchSelect ? asr_pkg::CONV_HIGH_CYC
                                                   : asr_pkg::CONV_LOW_CYC)); // see [R1] [R18]
  // an external sck frame is bounded only by its own 24 periods or a cs rise
  assign outTimeout = intMode_r
                    & (extClkMode_r ? (outCnt_r >= asr_pkg::DOUT_EXT_PERIODS) // see [R3]
                                    : (outCnt_r >= asr_pkg::DOUT_INT_CYC)); // see [R2] [R4]

  always_ff @(posedge clk) begin
    if (srst) begin
      state_r    <= asr_pkg::ST_CONVERT;
      convCnt_r  <= '0;
      outCnt_r   <= '0;
      bitCnt_r   <= '0;
      shift_r    <= asr_pkg::IDLE_FRAME;
      convDone_r <= 1'b0;
    end else begin
      convDone_r <= 1'b0;
      case (state_r)
        asr_pkg::ST_CONVERT: begin
          if (convEnd) begin
            state_r    <= asr_pkg::ST_SLEEP; // see [R11] [R20]
            convDone_r <= 1'b1;
            shift_r    <= frame_of(channelIndicator, polarityFlag,
                                   extendedRangeFlag, sampleData); // see [R11]
            convCnt_r  <= '0;
          end else if (convTick) begin
            convCnt_r <= convCnt_r + 32'd1;
          end
        end
        asr_pkg::ST_SLEEP: begin
          if (sckRise) begin
            state_r  <= asr_pkg::ST_OUTPUT; // see [R12]
            outCnt_r <= '0;
            bitCnt_r <= 5'd1;
          end
        end
        asr_pkg::ST_OUTPUT: begin
          if (csRise || outTimeout) begin
            state_r <= asr_pkg::ST_CONVERT; // see [R14] [R2] [R3]
          end else if (sckFall) begin
            if (bitCnt_r == 5'(asr_pkg::FRAME_BITS)) begin
              state_r <= asr_pkg::ST_CONVERT; // see [R17] [R4]
            end else begin
              shift_r <= {shift_r[22:0], 1'b0}; // see [R6]
            end
          end else if (sckRise) begin
            bitCnt_r <= bitCnt_r + 5'd1;
          end
          if (convTick && !sckFall && !csRise) begin
            outCnt_r <= outCnt_r + 32'd1;
          end
        end
        default: state_r <= asr_pkg::ST_CONVERT;
      endcase
    end
  end

  // internal serial clock: oscillator tick or external conversion clock divided by eight, gated off while cs is high or in convert
  always_ff @(posedge clk) begin
    if (srst) begin
      oscCnt_r <= '0;
      divCnt_r <= '0;
      sckDrv_r <= 1'b1;
    end else if (!intMode_r || link.csN || state_r == asr_pkg::ST_CONVERT) begin
      oscCnt_r <= '0;
      divCnt_r <= '0;
      sckDrv_r <= 1'b1;
    end else if (extClkMode_r ? extTick : (oscCnt_r == 2 * asr_pkg::OSC_HALF_CYC - 1)) begin
      oscCnt_r <= '0;
      divCnt_r <= divCnt_r + 3'd1; // see [R5] [R19]
      if (divCnt_r == 3'(asr_pkg::SCK_DIV / 2 - 1) || divCnt_r == 3'(asr_pkg::SCK_DIV - 1)) begin
        sckDrv_r <= ~sckDrv_r;
      end
    end else begin
      oscCnt_r <= oscCnt_r + 32'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sdo_r      <= 1'b1;
      sdoOe_r    <= 1'b0;
      sckOe_r    <= 1'b0;
      lowPower_r <= 1'b0;
    end else begin
      sdoOe_r    <= ~link.csN; // see [R9]
      // mode is stale in the cs fall cycle, so never drive sck there
      sckOe_r    <= intMode_r & ~link.csN & ~csFall; // see [R5] [R7]
      lowPower_r <= (state_r == asr_pkg::ST_SLEEP) & link.csN; // see [R13]
      case (state_r)
        asr_pkg::ST_CONVERT: sdo_r <= 1'b1; // see [R10] [R17]
        asr_pkg::ST_SLEEP:   sdo_r <= 1'b0; // see [R10]
        default:             sdo_r <= shift_r[23]; // see [R6] [R22]
      endcase
    end
  end

  assign link.sdo    = sdo_r;
  assign link.sdoOe  = sdoOe_r;
  assign link.sckOut = sckDrv_r;
  assign link.sckOe  = sckOe_r;
endmodule

// File: rtl/asr_host.sv
`timescale 1ns/1ps
module asr_host (
  input  wire logic        clk,
  input  wire logic        srst,
  asr_link_if.host         link,
  input  wire logic        readReq,
  input  wire logic        useExtSck,
  input  wire logic        notchHigh,
  input  wire logic [4:0]  abortAfter,
  output logic             frameValid_r,
  output logic [23:0]      frameData_r,
  output logic             busy_r
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_WAIT = 2'b01,
    HS_READ = 2'b10,
    HS_DONE = 2'b11
  } asr_host_state_type;
  asr_host_state_type hst_r;
  logic        csN_r;
  logic        sck_r;
  logic        sckOe_r;
  logic        notch_r;
  logic        sckPrev_r;
  logic [4:0]  bits_r;
  logic [23:0] rx_r;
  logic [2:0]  half_r;
  logic        rise;

  assign rise = ~sckPrev_r & link.sckLine;

  always_ff @(posedge clk) begin
    if (srst) begin
      hst_r        <= HS_IDLE;
      csN_r        <= 1'b1;
      sck_r        <= 1'b0;
      sckOe_r      <= 1'b0;
      notch_r      <= 1'b0;
      sckPrev_r    <= 1'b1;
      bits_r       <= '0;
      rx_r         <= '0;
      half_r       <= '0;
      frameValid_r <= 1'b0;
      frameData_r  <= '0;
      busy_r       <= 1'b0;
    end else begin
      sckPrev_r    <= link.sckLine;
      notch_r      <= notchHigh;
      frameValid_r <= 1'b0;
      case (hst_r)
        HS_IDLE: begin
          if (readReq) begin
            sckOe_r <= useExtSck; // see [R8] [R21]
            sck_r   <= 1'b0;
            csN_r   <= 1'b0;
            busy_r  <= 1'b1;
            bits_r  <= '0;
            rx_r    <= '0;
            half_r  <= '0;
            hst_r   <= HS_WAIT;
          end
        end
        HS_WAIT: begin
          if (!link.sdoLine) begin
            hst_r <= HS_READ;
          end
        end
        HS_READ: begin
          if (useExtSck) begin
            half_r <= half_r + 3'd1;
            if (half_r == 3'd7) begin
              sck_r <= ~sck_r;
            end
          end
          if (rise) begin
            rx_r   <= {rx_r[22:0], link.sdoLine}; // see [R16]
            bits_r <= bits_r + 5'd1;
            if (bits_r + 5'd1 == abortAfter) begin
              hst_r <= HS_DONE; // see [R15]
            end
          end
          if (bits_r == 5'd24 && !sck_r) begin
            hst_r <= HS_DONE;
          end
        end
        default: begin
          csN_r        <= 1'b1;
          sckOe_r      <= 1'b0;
          busy_r       <= 1'b0;
          frameValid_r <= 1'b1;
          frameData_r  <= rx_r;
          hst_r        <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.csN         = csN_r;
  assign link.hostSck     = sck_r;
  assign link.hostSckOe   = sckOe_r;
  assign link.notchSelect = notch_r;
endmodule

// File: tb/asr_link_sva.sv
`timescale 1ns/1ps
module asr_link_sva (
  input wire logic clk,
  input wire logic srst,
  input wire logic csN,
  input wire logic sckOut,
  input wire logic sckOe,
  input wire logic hostSckOe,
  input wire logic sdo,
  input wire logic sdoOe,
  input wire logic sckLine
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  logic [4:0] riseCnt_r;
  logic       sckLine_r;
  // counts resolved sck rises inside one chip-select window
  always_ff @(posedge clk) begin
    if (srst || csN) begin
      riseCnt_r <= 5'h00;
    end else if (sckLine && !sckLine_r) begin
      riseCnt_r <= riseCnt_r + 5'h01;
    end
  end
  always_ff @(posedge clk) begin
    sckLine_r <= sckLine;
  end
  sequence csHeldHigh;
    csN && $past(csN) && $past(csN, 2);
  endsequence
  sequence csHeldLow;
    !csN && !$past(csN) && !$past(csN, 2);
  endsequence
  sequence frameEnd;
    riseCnt_r == 5'h18 && $past(riseCnt_r) == 5'h17;
  endsequence
  sequence sckLowPhase;
    (!sckOut)[*7];
  endsequence
  sequence eocWindow;
    !csN && !$past(csN) && sdoOe && $past(sdoOe) && riseCnt_r == 5'h00;
  endsequence
  sequence dataStep;
    !csN && sdoOe && $past(sdoOe) && $changed(sdo) && riseCnt_r inside {[1:23]};
  endsequence
  sequence intSckFall;
    sckOe && $past(sckOe) && $fell(sckOut);
  endsequence
  a_sdo_released: assert property (csHeldHigh |-> !sdoOe)
    else $error("data line driven while chip select high");
  a_eoc_driven: assert property (csHeldLow |-> sdoOe)
    else $error("data line released while chip select low");
  a_eoc_before_read: assert property (eocWindow |-> !$rose(sdo))
    else $error("data line rose before first sck rise");
  a_shift_on_fall: assert property (dataStep |-> !($past(sckLine) && sckLine))
    else $error("data bit changed while sck high");
  a_sck_low_phase: assert property (intSckFall |-> sckLowPhase)
    else $error("internal sck low phase too short");
  a_one_driver: assert property (hostSckOe |-> !sckOe)
    else $error("sck driven from both ends");
  a_frame_len: assert property (!csN |-> riseCnt_r <= 5'h18)
    else $error("more than 24 sck rises in a frame");
  a_new_conv: assert property (frameEnd |-> ##[1:64] (sdo || csN))
    else $error("data line not high after frame end");
endmodule

// File: tb/adc_serial_readout_test.sv
`timescale 1ns/1ps
module adc_serial_readout_test;
  logic        clk;
  logic        srst;
  logic        readReq;
  logic        useExtSck;
  logic        notchHigh;
  logic [19:0] sampleData;
  logic [2:0]  flags;
  logic        lowPower;
  logic        extMode;
  logic        convDone;
  logic        frameValid;
  logic [23:0] frameData;
  logic        busy;
  logic [4:0]  abortAfter;
  logic [23:0] expQ[$];
  int          failCount;
  int          cmpCount;
  int          cycles;
  asr_link_if link ();
  asr_device asr_device_i (.clk(clk), .srst(srst), .link(link), .sampleData(sampleData),
    .channelIndicator(flags[2]), .polarityFlag(flags[1]), .extendedRangeFlag(flags[0]),
    .lowPower_r(lowPower), .extClkMode_r(extMode), .convDone_r(convDone));
  asr_host asr_host_i (.clk(clk), .srst(srst), .link(link), .readReq(readReq),
    .useExtSck(useExtSck), .notchHigh(notchHigh), .abortAfter(abortAfter),
    .frameValid_r(frameValid), .frameData_r(frameData), .busy_r(busy));
  asr_link_sva asr_link_sva_i (.clk(clk), .srst(srst), .csN(link.csN), .sckOut(link.sckOut),
    .sckOe(link.sckOe), .hostSckOe(link.hostSckOe), .sdo(link.sdo), .sdoOe(link.sdoOe),
    .sckLine(link.sckLine));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmpCount++;
    if (got !== exp) begin
      failCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // fastest conversion clock the edge detector can see keeps the run short
  always @(posedge clk) begin
    notchHigh <= srst ? 1'b0 : ~notchHigh;
    cycles++;
    if (cycles == 100000) begin
      failCount++;
      $display("Error run expected done seen timeout");
      report_and_stop();
    end
  end
  always @(negedge clk) begin
    if (frameValid === 1'b1) begin
      if (expQ.size() == 0) begin
        failCount++;
        $display("Error frameData expected none seen %h", frameData);
      end else begin
        check("frameData", expQ.pop_front(), frameData);
      end
    end
  end
  task automatic wait_for(input int limit, input bit forDone);
    int n;
    n = 0;
    while (n < limit && (forDone ? convDone !== 1'b1 : busy !== 1'b0)) begin
      @(negedge clk);
      n++;
    end
    if (n >= limit) begin
      failCount++;
      $display("Error wait expected event seen none");
    end
  endtask
  initial begin
    srst = 1'b1;
    readReq = 1'b0;
    useExtSck = 1'b0;
    abortAfter = 5'h00;
    sampleData = 20'h00000;
    flags = 3'h0;
    failCount = 0;
    cmpCount = 0;
    cycles = 0;
    void'($urandom(69080));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int t = 0; t < 2; t++) begin
      int k;
      // first read takes the whole frame, the second one stops after k bits
      k = (t == 0) ? 24 : 8 + int'($urandom % 16);
      @(posedge clk);
      sampleData <= 20'($urandom);
      flags <= 3'($urandom);
      abortAfter <= (t == 0) ? 5'h00 : 5'(k);
      wait_for(60000, 1'b1);
      repeat (4) @(negedge clk);
      check("lowPower", 24'h1, {23'h0, lowPower});
      check("extMode", 24'h1, {23'h0, extMode});
      expQ.push_back(24'({1'b0, flags, sampleData} >> (24 - k)));
      @(posedge clk);
      readReq <= 1'b1;
      useExtSck <= (t == 0);
      @(posedge clk);
      readReq <= 1'b0;
      repeat (3) @(negedge clk);
      wait_for(5000, 1'b0);
      repeat (4) @(negedge clk);
      check("lowPower", 24'h0, {23'h0, lowPower});
      $display("test read %0d done", t);
    end
    check("pending", 24'h0, 24'(expQ.size()));
    report_and_stop();
  end
endmodule
